// File: epd_seq_pkg.sv
package epd_seq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 5;
  localparam int WAKE_DEGLITCH_NS  = 500000;
  localparam int PWR_DEGLITCH_NS   = 400000;
  localparam int WAKE_READY_NS     = 100000;
  localparam int MS_NS             = 1000000;
  localparam int DISCHARGE_MS      = 100;
  // both deglitch times round down, least delays round up
  localparam int WAKE_DEGLITCH_CYC = WAKE_DEGLITCH_NS / CLK_PERIOD_NS;
  localparam int PWR_DEGLITCH_CYC  = PWR_DEGLITCH_NS / CLK_PERIOD_NS;
  localparam int WAKE_READY_CYC    = (WAKE_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_TICK_CYC       = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] DISCHARGE_TICKS = 8'(DISCHARGE_MS);

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ENABLE  = 8'h00;
  localparam logic [7:0] ADDR_UPORDER = 8'h04;
  localparam logic [7:0] ADDR_UPDLY   = 8'h08;
  localparam logic [7:0] ADDR_DNORDER = 8'h0C;
  localparam logic [7:0] ADDR_DNDLY   = 8'h10;
  localparam logic [7:0] ADDR_VOLT    = 8'h14;
  localparam logic [7:0] ADDR_TEMPTHR = 8'h18;
  localparam logic [7:0] ADDR_TEMPCTL = 8'h1C;
  localparam logic [7:0] ADDR_TEMPVAL = 8'h20;
  localparam logic [7:0] ADDR_FLAGS   = 8'h24;
  localparam logic [7:0] ADDR_MASK    = 8'h28;
  localparam logic [7:0] ADDR_STATUS  = 8'h2C;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int ENABLE_ACTIVE_BIT  = 0;
  localparam int ENABLE_STANDBY_BIT = 1;
  localparam int ENABLE_RAIL_LSB    = 2;
  localparam int DNDLY_FACTOR_LSB   = 16;
  localparam int TEMPCTL_TRIG_BIT   = 0;
  localparam int TEMPCTL_BUSY_BIT   = 1;
  localparam int FLAG_HOT           = 0;
  localparam int FLAG_THRESHOLD_A          = 1;
  localparam int FLAG_CHANGE        = 2;
  localparam int FLAG_DONE          = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  RAIL_EN_RST = 4'hF;
  localparam logic [7:0]  UPORDER_RST = 8'hE4;
  localparam logic [15:0] UPDLY_RST   = 16'h3333;
  localparam logic [7:0]  DNORDER_RST = 8'h1B;
  localparam logic [15:0] DNDLY_RST   = 16'h3333;
  localparam logic [3:0]  FACTOR_RST  = 4'h1;
  localparam logic [8:0]  VOLT_RST    = 9'h000;
  localparam logic [31:0] TEMPTHR_RST = 32'h0005_0032;
  localparam logic [3:0]  MASK_RST    = 4'h0;

  typedef enum logic [3:0] {
    ST_SLEEP     = 4'h0,
    ST_WAKING    = 4'h1,
    ST_STANDBY   = 4'h2,
    ST_UP_NEG    = 4'h3,
    ST_UP_POS    = 4'h4,
    ST_UP_DLY    = 4'h5,
    ST_UP_PG     = 4'h6,
    ST_ACTIVE    = 4'h7,
    ST_DN_DLY    = 4'h8,
    ST_DISCHARGE = 4'h9
  } seq_state_t;

endpackage

// File: pin_deglitch.sv
`timescale 1ns/1ps
module pin_deglitch #(
  parameter int STABLE_CYCLES = 100000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pinIn,
  output logic      level
);
  logic       syncA;
  logic       syncB;
  logic [31:0] stableCnt;

  // ----------------------------------------------------------------
  // two-flop synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
    end else begin
      syncA <= pinIn;
      syncB <= syncA;
    end
  end

  // ----------------------------------------------------------------
  // level follows only after it has stood for the whole window
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      stableCnt <= 32'h0000_0000;
      level     <= 1'b0;
    end else if (syncB == level) begin
      stableCnt <= 32'h0000_0000;
    end else if (stableCnt >= 32'(STABLE_CYCLES - 1)) begin
      stableCnt <= 32'h0000_0000;
      level     <= syncB;
    end else begin
      stableCnt <= stableCnt + 32'h0000_0001;
    end
  end
endmodule

// File: epd_pmic_sequence_monitor.sv
`timescale 1ns/1ps
module epd_pmic_sequence_monitor #(
  parameter int WAKE_DEGLITCH_CYCLES = epd_seq_pkg::WAKE_DEGLITCH_CYC,
  parameter int PWR_DEGLITCH_CYCLES  = epd_seq_pkg::PWR_DEGLITCH_CYC,
  parameter int WAKE_READY_CYCLES    = epd_seq_pkg::WAKE_READY_CYC,
  parameter int MS_TICK_CYCLES       = epd_seq_pkg::MS_TICK_CYC,
  parameter int RAILS                = 4
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              wakeRequestPin,
  input  wire logic              railPowerRequestPin,
  input  wire logic [RAILS-1:0]  railPowerGood,
  input  wire logic              negBoostPowerGood,
  input  wire logic              posBoostPowerGood,
  output logic [RAILS-1:0]       railEnable,
  output logic                   negBoostEnable,
  output logic                   posBoostEnable,
  output logic                   railsOkOut,
  output logic                   railsOkOe,
  output logic [8:0]             voltSetting,
  output logic                   adcStart,
  input  wire logic              adcDone,
  input  wire logic [7:0]        adcValue,
  output logic                   tempAlert
);
  epd_seq_pkg::seq_state_t state;

  logic wakeLvl;
  logic pwrLvl;
  logic pwrLvlD;
  logic pwrRise;
  logic pwrFall;
  logic regRst;
  logic busOn;
  logic upReq;
  logic dnReq;
  logic pendUp;
  logic msTick;
  logic [31:0] msCnt;
  logic [31:0] readyCnt;
  logic [7:0]  dlyCnt;
  logic [1:0]  strobe;
  logic [RAILS-1:0] railOn;
  logic [RAILS-1:0] pgSyncA;
  logic [RAILS-1:0] pgSyncB;
  logic [1:0]  boostSyncA;
  logic [1:0]  boostSyncB;
  logic [RAILS-1:0] strobeUpHit;
  logic [RAILS-1:0] strobeDnHit;
  logic [RAILS-1:0] upDoneMask;

  logic        dataPhase;
  logic        dataWrite;
  logic [7:0]  dataAddr;
  logic        wrEn;
  logic [3:0]  railEnReg;
  logic [7:0]  upOrderReg;
  logic [15:0] upDlyReg;
  logic [7:0]  dnOrderReg;
  logic [15:0] dnDlyReg;
  logic [3:0]  factorReg;
  logic [8:0]  voltReg;
  logic [31:0] tempThrReg;
  logic [7:0]  readingReg;
  logic [3:0]  flagsReg;
  logic [3:0]  maskReg;
  logic [3:0]  flagSet;
  logic        tempBusy;
  logic        activeCmd;
  logic        standbyCmd;
  logic        trigCmd;
  logic signed [8:0] tempDiff;

  // ----------------------------------------------------------------
  // pin conditioning
  // ----------------------------------------------------------------
  pin_deglitch #(.STABLE_CYCLES(WAKE_DEGLITCH_CYCLES)) wakeFilter (
    .clk   (clk),
    .rst   (rst),
    .pinIn (wakeRequestPin),
    .level (wakeLvl)
  );

  pin_deglitch #(.STABLE_CYCLES(PWR_DEGLITCH_CYCLES)) pwrFilter (
    .clk   (clk),
    .rst   (rst),
    .pinIn (railPowerRequestPin),
    .level (pwrLvl)
  );

  // analog power-good levels come from another domain
  always_ff @(posedge clk) begin
    if (rst) begin
      pgSyncA    <= '0;
      pgSyncB    <= '0;
      boostSyncA <= 2'h0;
      boostSyncB <= 2'h0;
      pwrLvlD    <= 1'b0;
    end else begin
      pgSyncA    <= railPowerGood;
      pgSyncB    <= pgSyncA;
      boostSyncA <= {posBoostPowerGood, negBoostPowerGood};
      boostSyncB <= boostSyncA;
      pwrLvlD    <= pwrLvl;
    end
  end

  assign pwrRise = pwrLvl && !pwrLvlD;
  assign pwrFall = !pwrLvl && pwrLvlD;
  assign upReq   = pwrRise || activeCmd;
  assign dnReq   = pwrFall || standbyCmd;
  assign regRst  = rst || (state == epd_seq_pkg::ST_SLEEP);
  assign busOn   = (state != epd_seq_pkg::ST_SLEEP) && (state != epd_seq_pkg::ST_WAKING);

  // ----------------------------------------------------------------
  // millisecond time base for sequence delays
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || msCnt >= 32'(MS_TICK_CYCLES - 1)) begin
      msCnt <= 32'h0000_0000;
    end else begin
      msCnt <= msCnt + 32'h0000_0001;
    end
  end
  assign msTick = (msCnt == 32'(MS_TICK_CYCLES - 1));

  // ----------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------
  for (genvar i = 0; i < RAILS; i++) begin : gStrobe
    assign strobeUpHit[i] = (upOrderReg[2*i +: 2] == strobe);
    assign strobeDnHit[i] = (dnOrderReg[2*i +: 2] == strobe);
    assign upDoneMask[i]  = (upOrderReg[2*i +: 2] <= strobe) && railEnReg[i];
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state          <= epd_seq_pkg::ST_SLEEP;
      readyCnt       <= 32'h0000_0000;
      dlyCnt         <= 8'h00;
      strobe         <= 2'h0;
      railOn         <= '0;
      negBoostEnable <= 1'b0;
      posBoostEnable <= 1'b0;
      pendUp         <= 1'b0;
    end else begin
      if (msTick && dlyCnt != 8'h00) begin
        dlyCnt <= dlyCnt - 8'h01;
      end
      unique case (state)
        epd_seq_pkg::ST_SLEEP: begin
          railOn   <= '0;
          readyCnt <= 32'h0000_0000;
          if (wakeLvl) begin
            state <= epd_seq_pkg::ST_WAKING;
          end
        end
        epd_seq_pkg::ST_WAKING: begin
          readyCnt <= readyCnt + 32'h0000_0001;
          if (!wakeLvl) begin
            state <= epd_seq_pkg::ST_SLEEP;
          end else if (readyCnt >= 32'(WAKE_READY_CYCLES - 1)) begin
            state <= pwrLvl ? epd_seq_pkg::ST_UP_NEG : epd_seq_pkg::ST_STANDBY;
          end
        end
        epd_seq_pkg::ST_STANDBY: begin
          if (!wakeLvl) begin
            state <= epd_seq_pkg::ST_SLEEP;
          end else if (upReq) begin
            state <= epd_seq_pkg::ST_UP_NEG;
          end
        end
        epd_seq_pkg::ST_ACTIVE: begin
          if (dnReq || !wakeLvl) begin
            state  <= epd_seq_pkg::ST_DN_DLY;
            strobe <= 2'h0;
            dlyCnt <= {4'h0, dnDlyReg[3:0]};
          end
        end
        epd_seq_pkg::ST_DN_DLY: begin
          if (upReq) begin
            pendUp <= 1'b1;
          end
          if (dlyCnt == 8'h00) begin
            railOn <= railOn & ~strobeDnHit;
            strobe <= strobe + 2'h1;
            dlyCnt <= 8'(dnDlyReg[4*(strobe+2'h1) +: 4] * factorReg);
            if (strobe == 2'h3) begin
              posBoostEnable <= 1'b0;
              dlyCnt         <= epd_seq_pkg::DISCHARGE_TICKS;
              state          <= epd_seq_pkg::ST_DISCHARGE;
            end
          end
        end
        epd_seq_pkg::ST_DISCHARGE: begin
          if ((pendUp || upReq) && wakeLvl) begin
            // discharge is cut short; negative boost is still up
            pendUp <= 1'b0;
            state  <= epd_seq_pkg::ST_UP_NEG;
          end else if (dlyCnt == 8'h00) begin
            negBoostEnable <= 1'b0;
            pendUp         <= 1'b0;
            state          <= wakeLvl ? epd_seq_pkg::ST_STANDBY : epd_seq_pkg::ST_SLEEP;
          end
        end
        default: begin
          // power-up states; any abort goes straight to power-down
          if (dnReq || !wakeLvl) begin
            state  <= epd_seq_pkg::ST_DN_DLY;
            strobe <= 2'h0;
            dlyCnt <= {4'h0, dnDlyReg[3:0]};
          end else if (state == epd_seq_pkg::ST_UP_NEG) begin
            negBoostEnable <= 1'b1;
            if (negBoostEnable && boostSyncB[0]) begin
              state <= epd_seq_pkg::ST_UP_POS;
            end
          end else if (state == epd_seq_pkg::ST_UP_POS) begin
            posBoostEnable <= 1'b1;
            if (posBoostEnable && boostSyncB[1]) begin
              state  <= epd_seq_pkg::ST_UP_DLY;
              strobe <= 2'h0;
              dlyCnt <= {4'h0, upDlyReg[3:0]};
            end
          end else if (state == epd_seq_pkg::ST_UP_DLY) begin
            if (dlyCnt == 8'h00) begin
              railOn <= railOn | strobeUpHit;
              state  <= epd_seq_pkg::ST_UP_PG;
            end
          end else if ((pgSyncB & upDoneMask) == upDoneMask) begin
            if (strobe == 2'h3) begin
              state <= epd_seq_pkg::ST_ACTIVE;
            end else begin
              strobe <= strobe + 2'h1;
              dlyCnt <= {4'h0, upDlyReg[4*(strobe+2'h1) +: 4]};
              state  <= epd_seq_pkg::ST_UP_DLY;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // rail outputs and rails-ok
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      railEnable <= '0;
      railsOkOe  <= 1'b1;
      railsOkOut <= 1'b0;
    end else begin
      railEnable <= railOn & railEnReg;
      // judged on the enables being loaded now, so rails-ok never lags a disabled rail
      railsOkOe  <= ((railOn & railEnReg & pgSyncB) != {RAILS{1'b1}});
      railsOkOut <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bus slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr  <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dataPhase <= hsel && htrans[1] && hready && busOn;
      dataWrite <= hwrite;
      dataAddr  <= haddr[7:0];
      hrdata    <= 32'h0000_0000;
      if (hsel && htrans[1] && hready && !hwrite && busOn) begin
        unique case (haddr[7:0])
          epd_seq_pkg::ADDR_ENABLE:  hrdata <= {26'h0, railEnReg, 2'h0};
          epd_seq_pkg::ADDR_UPORDER: hrdata <= {24'h0, upOrderReg};
          epd_seq_pkg::ADDR_UPDLY:   hrdata <= {16'h0, upDlyReg};
          epd_seq_pkg::ADDR_DNORDER: hrdata <= {24'h0, dnOrderReg};
          epd_seq_pkg::ADDR_DNDLY:   hrdata <= {12'h0, factorReg, dnDlyReg};
          epd_seq_pkg::ADDR_VOLT:    hrdata <= {23'h0, voltReg};
          epd_seq_pkg::ADDR_TEMPTHR: hrdata <= tempThrReg;
          epd_seq_pkg::ADDR_TEMPCTL: hrdata <= {30'h0, tempBusy, 1'b0};
          epd_seq_pkg::ADDR_TEMPVAL: hrdata <= {24'h0, readingReg};
          epd_seq_pkg::ADDR_FLAGS:   hrdata <= {28'h0, flagsReg};
          epd_seq_pkg::ADDR_MASK:    hrdata <= {28'h0, maskReg};
          epd_seq_pkg::ADDR_STATUS:  hrdata <= {17'h0, railsOkOe, posBoostEnable, negBoostEnable,
                                               pgSyncB, railEnable, state};
          default:                   hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wrEn       = dataPhase && dataWrite;
  assign activeCmd  = wrEn && dataAddr == epd_seq_pkg::ADDR_ENABLE && hwdata[epd_seq_pkg::ENABLE_ACTIVE_BIT];
  assign standbyCmd = wrEn && dataAddr == epd_seq_pkg::ADDR_ENABLE && hwdata[epd_seq_pkg::ENABLE_STANDBY_BIT];
  assign trigCmd    = wrEn && dataAddr == epd_seq_pkg::ADDR_TEMPCTL && hwdata[epd_seq_pkg::TEMPCTL_TRIG_BIT];

  // ----------------------------------------------------------------
  // configuration registers, held at their reset values while asleep
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (regRst) begin
      railEnReg  <= epd_seq_pkg::RAIL_EN_RST;
      upOrderReg <= epd_seq_pkg::UPORDER_RST;
      upDlyReg   <= epd_seq_pkg::UPDLY_RST;
      dnOrderReg <= epd_seq_pkg::DNORDER_RST;
      dnDlyReg   <= epd_seq_pkg::DNDLY_RST;
      factorReg  <= epd_seq_pkg::FACTOR_RST;
      voltReg    <= epd_seq_pkg::VOLT_RST;
      tempThrReg <= epd_seq_pkg::TEMPTHR_RST;
      maskReg    <= epd_seq_pkg::MASK_RST;
    end else if (wrEn) begin
      unique case (dataAddr)
        epd_seq_pkg::ADDR_ENABLE:  railEnReg  <= hwdata[epd_seq_pkg::ENABLE_RAIL_LSB +: 4];
        epd_seq_pkg::ADDR_UPORDER: upOrderReg <= hwdata[7:0];
        epd_seq_pkg::ADDR_UPDLY:   upDlyReg   <= hwdata[15:0];
        epd_seq_pkg::ADDR_DNORDER: dnOrderReg <= hwdata[7:0];
        epd_seq_pkg::ADDR_DNDLY: begin
          dnDlyReg  <= hwdata[15:0];
          factorReg <= hwdata[epd_seq_pkg::DNDLY_FACTOR_LSB +: 4];
        end
        epd_seq_pkg::ADDR_VOLT:    voltReg    <= hwdata[8:0];
        epd_seq_pkg::ADDR_TEMPTHR: tempThrReg <= hwdata;
        epd_seq_pkg::ADDR_MASK:    maskReg    <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      voltSetting <= epd_seq_pkg::VOLT_RST;
    end else begin
      voltSetting <= voltReg;
    end
  end

  // ----------------------------------------------------------------
  // temperature measurement
  // ----------------------------------------------------------------
  assign tempDiff = $signed({adcValue[7], adcValue}) - $signed({tempThrReg[31], tempThrReg[31:24]});

  always_comb begin
    flagSet = 4'h0;
    if (tempBusy && adcDone) begin
      flagSet[epd_seq_pkg::FLAG_DONE]   = 1'b1;
      flagSet[epd_seq_pkg::FLAG_HOT]    = $signed(adcValue) > $signed(tempThrReg[7:0]);
      flagSet[epd_seq_pkg::FLAG_THRESHOLD_A]   = $signed(adcValue) < $signed(tempThrReg[15:8]);
      flagSet[epd_seq_pkg::FLAG_CHANGE] = (tempDiff > $signed({1'b0, tempThrReg[23:16]})) ||
                                          (-tempDiff > $signed({1'b0, tempThrReg[23:16]}));
    end
  end

  always_ff @(posedge clk) begin
    if (regRst) begin
      tempBusy   <= 1'b0;
      adcStart   <= 1'b0;
      readingReg <= 8'h00;
      flagsReg   <= 4'h0;
      tempAlert  <= 1'b0;
    end else begin
      adcStart <= trigCmd && !tempBusy;
      if (trigCmd && !tempBusy) begin
        tempBusy <= 1'b1;
      end else if (adcDone) begin
        tempBusy <= 1'b0;
      end
      if (tempBusy && adcDone) begin
        readingReg <= adcValue;
      end
      // write-one-to-clear, a new event wins over the clear
      if (wrEn && dataAddr == epd_seq_pkg::ADDR_FLAGS) begin
        flagsReg <= (flagsReg & ~hwdata[3:0]) | flagSet;
      end else begin
        flagsReg <= flagsReg | flagSet;
      end
      tempAlert <= |(flagsReg & ~maskReg);
    end
  end
endmodule

// File: epd_pmic_sequence_monitor_properties.sv
`timescale 1ns/1ps
module epd_pmic_sequence_monitor_properties #(
  parameter int MS_TICK_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic [3:0]  railEnable,
  input wire logic        negBoostEnable,
  input wire logic        posBoostEnable,
  input wire logic        railsOkOe,
  input wire logic        adcStart
);
  // first ms tick may come early, so one tick of slack
  localparam int DISCH_MIN = 99 * MS_TICK_CYCLES;
  int offCnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  always_ff @(posedge clk) begin
    if (rst || !negBoostEnable || posBoostEnable || railEnable != 4'h0) offCnt <= 0;
    else offCnt <= offCnt + 1;
  end

  property p_okNeedsRails; !railsOkOe |-> railEnable == 4'hF && negBoostEnable && posBoostEnable; endproperty
  a_okNeedsRails: assert property (p_okNeedsRails) else $error("rails ok released with a rail off");
  property p_okDrops; railEnable != 4'hF |-> ##[0:3] railsOkOe; endproperty
  a_okDrops: assert property (p_okDrops) else $error("rails ok not pulled low");
  property p_posAfterNeg; posBoostEnable |-> negBoostEnable; endproperty
  a_posAfterNeg: assert property (p_posAfterNeg) else $error("positive boost without negative");
  property p_railsAfterPos; $rose(|railEnable) |-> posBoostEnable; endproperty
  a_railsAfterPos: assert property (p_railsAfterPos) else $error("rail on before positive boost");
  property p_discharge; $fell(negBoostEnable) |-> offCnt >= DISCH_MIN; endproperty
  a_discharge: assert property (p_discharge) else $error("discharge delay cut short");
  property p_adcPulse; adcStart |=> !adcStart; endproperty
  a_adcPulse: assert property (p_adcPulse) else $error("conversion start not a pulse");
  property p_rdZero; hrdata != 32'h0 |-> $past(hsel && htrans[1] && !hwrite && hready); endproperty
  a_rdZero: assert property (p_rdZero) else $error("read data without a read");
  property p_negOff; !negBoostEnable |-> railEnable == 4'h0 && railsOkOe; endproperty
  a_negOff: assert property (p_negOff) else $error("rail on without negative boost");
endmodule

bind epd_pmic_sequence_monitor epd_pmic_sequence_monitor_properties #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) uProps (
  .clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .railEnable(railEnable), .negBoostEnable(negBoostEnable), .posBoostEnable(posBoostEnable),
  .railsOkOe(railsOkOe), .adcStart(adcStart));

// File: rail_plant.sv
`timescale 1ns/1ps
module rail_plant (
  input  wire logic       clk,
  input  wire logic [3:0] railEnable,
  input  wire logic       negBoostEnable,
  input  wire logic       posBoostEnable,
  input  wire logic       adcStart,
  input  wire logic [7:0] reading,
  output logic [3:0]      railPowerGood,
  output logic            negBoostPowerGood,
  output logic            posBoostPowerGood,
  output logic            adcDone,
  output logic [7:0]      adcValue
);
  logic [3:0] railDly;
  logic [2:0] negDly;
  logic [2:0] posDly;
  logic [3:0] adcDly;
  always_ff @(posedge clk) begin
    railDly       <= railEnable;
    railPowerGood <= railDly & railEnable;
    negDly        <= {negDly[1:0], negBoostEnable};
    posDly        <= {posDly[1:0], posBoostEnable};
    adcDly        <= {adcDly[2:0], adcStart};
  end
  assign negBoostPowerGood = negDly[2] & negBoostEnable;
  assign posBoostPowerGood = posDly[2] & posBoostEnable;
  assign adcDone           = adcDly[3];
  // value is garbage unless qualified by done
  assign adcValue          = adcDone ? reading : ~reading;
endmodule

// File: test_epd_pmic_sequence_monitor.sv
`timescale 1ns/1ps
module test_epd_pmic_sequence_monitor;
  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp, wake, pwr;
  logic        negPg, posPg, negEn, posEn, okOut, okOe, adcStart, adcDone, tempAlert;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  railPg, railEn;
  logic [8:0]  volt;
  logic [7:0]  adcValue, reading;
  int          fails, compares;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  assign hready = hreadyout;

  epd_pmic_sequence_monitor #(.WAKE_DEGLITCH_CYCLES(8), .PWR_DEGLITCH_CYCLES(8), .WAKE_READY_CYCLES(16),
    .MS_TICK_CYCLES(20)) DUT (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .wakeRequestPin(wake), .railPowerRequestPin(pwr), .railPowerGood(railPg), .negBoostPowerGood(negPg),
    .posBoostPowerGood(posPg), .railEnable(railEn), .negBoostEnable(negEn), .posBoostEnable(posEn),
    .railsOkOut(okOut), .railsOkOe(okOe), .voltSetting(volt), .adcStart(adcStart), .adcDone(adcDone),
    .adcValue(adcValue), .tempAlert(tempAlert));

  rail_plant plant (.clk(clk), .railEnable(railEn), .negBoostEnable(negEn), .posBoostEnable(posEn),
    .adcStart(adcStart), .reading(reading), .railPowerGood(railPg), .negBoostPowerGood(negPg),
    .posBoostPowerGood(posPg), .adcDone(adcDone), .adcValue(adcValue));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({30'h0, hresp, okOut}, 32'h0);
  endtask

  task automatic waitOe(input logic lvl);
    for (int i = 0; i < 6000 && okOe !== lvl; i++) @(posedge clk);
  endtask

  task automatic t_wake;
    wake <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, epd_seq_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd, 32'h0);
    repeat (60) @(posedge clk);
    bus(1'b0, epd_seq_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd[3:0], 32'h2);
    bus(1'b0, epd_seq_pkg::ADDR_UPORDER, 32'h0, rd);
    chk(rd, 32'hE4);
    bus(1'b1, epd_seq_pkg::ADDR_VOLT, 32'h1AB, rd);
    bus(1'b0, epd_seq_pkg::ADDR_VOLT, 32'h0, rd);
    chk(rd, 32'h1AB);
    chk(volt, 32'h1AB);
    bus(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 32'h0);
  endtask

  task automatic t_power;
    pwr <= 1'b1;
    waitOe(1'b0);
    chk(railEn, 32'hF);
    chk({30'h0, negEn, posEn}, 32'h3);
    bus(1'b0, epd_seq_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd[3:0], 32'h7);
    bus(1'b1, epd_seq_pkg::ADDR_ENABLE, 32'h38, rd);
    repeat (4) @(posedge clk);
    chk(railEn, 32'hE);
    chk(okOe, 32'h1);
    bus(1'b1, epd_seq_pkg::ADDR_ENABLE, 32'h3E, rd);
    for (int i = 0; i < 6000 && negEn !== 1'b0; i++) @(posedge clk);
    bus(1'b0, epd_seq_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd[3:0], 32'h2);
    chk({30'h0, negEn, posEn}, 32'h0);
    bus(1'b1, epd_seq_pkg::ADDR_ENABLE, 32'h3D, rd);
    waitOe(1'b0);
    bus(1'b0, epd_seq_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd[3:0], 32'h7);
  endtask

  task automatic temp(input logic [7:0] v, input logic [3:0] flags, input logic alert);
    reading <= v;
    bus(1'b1, epd_seq_pkg::ADDR_TEMPCTL, 32'h1, rd);
    repeat (12) @(posedge clk);
    bus(1'b0, epd_seq_pkg::ADDR_TEMPVAL, 32'h0, rd);
    chk(rd, {24'h0, v});
    bus(1'b0, epd_seq_pkg::ADDR_FLAGS, 32'h0, rd);
    chk(rd, {28'h0, flags});
    chk(tempAlert, {31'h0, alert});
    bus(1'b1, epd_seq_pkg::ADDR_FLAGS, 32'hF, rd);
    bus(1'b0, epd_seq_pkg::ADDR_FLAGS, 32'h0, rd);
    chk(rd, 32'h0);
  endtask

  task automatic t_sleep;
    wake <= 1'b0;
    for (int i = 0; i < 6000 && negEn !== 1'b0; i++) @(posedge clk);
    repeat (5) @(posedge clk);
    chk(volt, 32'h0);
    bus(1'b0, epd_seq_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd, 32'h0);
    wake <= 1'b1;
    waitOe(1'b0);
    chk(railEn, 32'hF);
  endtask

  task automatic end_of_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    hsize = 3'h2;
    wake = 1'b0; pwr = 1'b0; reading = 8'h0; fails = 0; compares = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_wake();
    t_power();
    bus(1'b1, epd_seq_pkg::ADDR_TEMPTHR, 32'h0005_0532, rd);
    temp(8'h40, 4'hD, 1'b1);
    bus(1'b1, epd_seq_pkg::ADDR_MASK, 32'hF, rd);
    temp(8'hEC, 4'hE, 1'b0);
    t_sleep();
    end_of_test();
  end
endmodule
